/* bcs_pkg.sv */
/*
  Shared types and constants of the buck fault and bias supervisor.
  Assumes a 40 MHz hclk; all time figures are turned into cycle counts here.
*/
package bcs_pkg;

  localparam int unsigned BCS_CLK_NS = 25;
  localparam int unsigned BCS_PER_W  = 12;
  localparam int unsigned BCS_SS_W   = 11;
  localparam int unsigned BCS_HIC_W  = 20;

  // sample window and short-off-time sample delay
  localparam int unsigned BCS_SMP_WIN_NS  = 30;
  localparam int unsigned BCS_SMP_WIN_CYC =
    (BCS_SMP_WIN_NS / BCS_CLK_NS < 1) ? 1 : BCS_SMP_WIN_NS / BCS_CLK_NS;
  localparam int unsigned BCS_SMP_DLY_NS  = 40;
  localparam int unsigned BCS_SMP_DLY_CYC =
    (BCS_SMP_DLY_NS + BCS_CLK_NS - 1) / BCS_CLK_NS;
  localparam int unsigned BCS_EIGHTH_SHIFT = 3;
  // drive register plus two synchroniser stages between a drive and its sense
  localparam int unsigned BCS_SENSE_LAT_CYC = 3;

  // hiccup interval
  localparam int unsigned BCS_HICCUP_US  = 20480;
  localparam int unsigned BCS_HICCUP_CYC = BCS_HICCUP_US * 1000 / BCS_CLK_NS;

  // soft-start: one code step is 1 mV, rate 0.4 mV/us = 400 uV/us
  localparam int unsigned BCS_SS_RATE_UV_US = 400;
  localparam int unsigned BCS_SS_STEP_CYC =
    (1000 * 1000 / BCS_SS_RATE_UV_US) / BCS_CLK_NS;
  localparam logic [10:0] BCS_SS_TOP_MV = 11'h5DC;

  localparam logic [8:0]  BCS_ZC_COUNT   = 9'h100;
  localparam logic [11:0] BCS_PER_MIN    = 12'h008;
  localparam logic [11:0] BCS_SYNC_MAX   = 12'hFFF;
  localparam logic [11:0] BCS_PER_RESET  = 12'h042;
  localparam logic [11:0] BCS_DUTY_RESET = 12'h008;

  // overcurrent limits for the three strap states (sense code units)
  localparam logic [7:0] BCS_LIM_FLOAT = 8'h80;
  localparam logic [7:0] BCS_LIM_HIGH  = 8'hC0;
  localparam logic [7:0] BCS_LIM_LOW   = 8'h40;

  localparam logic [31:0] BCS_REG_PERIOD = 32'h0000_0000;
  localparam logic [31:0] BCS_REG_DUTY   = 32'h0000_0004;
  localparam logic [31:0] BCS_REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] BCS_REG_LEVEL  = 32'h0000_000C;

  typedef enum logic [2:0] {
    BCS_OFF, BCS_SS, BCS_RUN, BCS_HIC, BCS_HOT
  } bcs_mode_t;

  typedef struct packed {
    logic       enable_ok;
    logic       bias_ok;
    logic       thermal_trip;
    logic       zero_cross;
    logic       power_input_high;
    logic       freq_set_sync_input;
    logic       strap_high;
    logic       strap_low;
    logic [7:0] ls_current;
  } bcs_sense_t;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
    logic ldo_high;
    logic feed_forward_on;
    logic overcurrent_flag;
  } bcs_drive_t;

  typedef struct packed {
    logic [23:0] rsv;
    logic        ext_sync;
    logic        feed_fwd;
    logic        ldo_high;
    logic        thermal;
    logic        oc;
    logic [2:0]  mode;
  } bcs_status_t;

endpackage

/* bcs_fault_bias.sv */
/*
  Supervisor of a synchronous buck stage: PWM timing, overcurrent hiccup,
  thermal restart, sync handover, feed-forward select and gate-bias level,
  with an AHB-Lite register slave.
  Assumes sense comparators arrive asynchronously and the bus runs on hclk.
*/
// The address map and the AHB-Lite register port were decided locally.
// Overview of operation
// - enable below shutdown threshold forces both gate drives off.
// - strap state (float, high, low) selects one of three current limits.
// - sample low-side current one 30 ns window, period/8 before the valley.
// - with low-side on under period/8, sample 40 ns after it turns on.
// - sampled current above the selected limit is an overcurrent event.
// - on overcurrent latch the flag and hold soft-start at zero 20.48 ms.
// - after hiccup clear the flag and soft-start again; repeat while overloaded.
// - thermal trip turns both switches off and resets soft-start.
// - when temperature recovers restart automatically through soft-start.
// - arriving sync clock moves the period gradually toward its period.
// - removed sync clock returns the period gradually to free-running.
// - feed-forward ramp on above 6.2 V input, fixed ramp below.
// - 256 consecutive zero crossings at low-side fall select 4.4 V bias.
// - a cycle without zero crossing clears the count, bias back to 6.8 V.
// - a turn-on from OFF starts with the 6.8 V bias level.
// - with enable low the bias level is 4.4 V.
// - soft-start begins only when bias and enable are both ready.
// - soft-start ramps 0.4 mV/us from zero up to 1.5 V.
// - overcurrent detection stays active during every soft-start.
`timescale 1ns/100ps
module bcs_fault_bias
  import bcs_pkg::*;
#(
  parameter int unsigned HICCUP_CYC = BCS_HICCUP_CYC
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire bcs_sense_t  sense,
  output bcs_drive_t       drive,
  output logic      [10:0] ss_level
);

  typedef struct packed {
    bcs_sense_t             s1;
    bcs_sense_t             s2;
    logic                   sync_d;
    bcs_mode_t              st;
    logic [BCS_SS_W-1:0]    ss;
    logic [7:0]             ss_div;
    logic [BCS_HIC_W-1:0]   hic;
    logic                   oc;
    logic [BCS_PER_W-1:0]   phase;
    logic [BCS_PER_W-1:0]   per;
    logic [BCS_PER_W-1:0]   per_fr;
    logic [BCS_PER_W-1:0]   duty;
    logic [BCS_PER_W-1:0]   ext_per;
    logic [BCS_PER_W-1:0]   ext_cnt;
    logic                   ext_ok;
    logic [8:0]             zc_cnt;
    logic [1:0]             ls_hist;
    logic                   a_wr;
    logic [31:0]            a_addr;
    logic [31:0]            rdata;
    bcs_drive_t             drv;
  } bcs_fb_state_t;

  bcs_fb_state_t           s;
  bcs_fb_state_t           next_s;
  logic                    por;
  logic                    hot;
  logic                    active;
  logic                    samp_hit;
  logic                    over;
  logic                    hs_on;
  logic                    ls_on;
  logic                    ls_fall;
  logic                    ap;
  logic [BCS_PER_W-1:0]    duty_e;
  logic [BCS_PER_W-1:0]    eighth;
  logic [BCS_PER_W-1:0]    samp;
  logic [BCS_PER_W-1:0]    tgt;
  bcs_status_t             stat;

  // three-state strap: both sense bits are decoded from one pin
  function automatic logic [7:0] oc_limit(input logic hi, input logic lo);
    oc_limit = hi ? BCS_LIM_HIGH : (lo ? BCS_LIM_LOW : BCS_LIM_FLOAT);
  endfunction

  function automatic logic [BCS_PER_W-1:0] step_to(
    input logic [BCS_PER_W-1:0] cur,
    input logic [BCS_PER_W-1:0] dst);
    if (cur < dst)
      step_to = cur + 12'h001;
    else if (cur > dst)
      step_to = cur - 12'h001;
    else
      step_to = cur;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.s1 = sense;
    next_s.s2 = s.s1;
    next_s.sync_d = s.s2.freq_set_sync_input;
    // low-side drive as it stood when the synchronised current was taken
    next_s.ls_hist = {s.ls_hist[0], s.drv.low_side_drive};

    por = s.s2.enable_ok && s.s2.bias_ok;
    hot = s.s2.thermal_trip;
    active = (s.st == BCS_SS) || (s.st == BCS_RUN);

    // pwm timing within one switching period
    duty_e = (s.duty < s.per) ? s.duty : s.per - 12'h001;
    eighth = s.per >> BCS_EIGHTH_SHIFT;
    if (s.per - duty_e >= eighth)
      samp = s.per - eighth;
    else
      // sense latency added; no sample if the low side ends before that
      samp = duty_e + 12'(BCS_SMP_DLY_CYC + BCS_SENSE_LAT_CYC);
    // a stale sample from before the low side conducted would false-trip
    samp_hit = active && s.ls_hist[1] && (s.phase >= samp)
               && (s.phase < samp + BCS_SMP_WIN_CYC[BCS_PER_W-1:0]);
    over = s.s2.ls_current
           > oc_limit(s.s2.strap_high, s.s2.strap_low);
    hs_on = active && por && !hot && (s.phase < duty_e);
    ls_on = active && por && !hot && !hs_on;
    ls_fall = s.drv.low_side_drive && !ls_on;

    // period walks one cycle per switching period, never jumps
    tgt = s.ext_ok ? s.ext_per : s.per_fr;
    if (s.phase >= s.per - 12'h001)
    begin
      next_s.phase = '0;
      next_s.per = step_to(s.per, tgt);
    end
    else
      next_s.phase = s.phase + 12'h001;

    // sync period measured edge to edge; a long gap means it is gone
    if (s.s2.freq_set_sync_input && !s.sync_d)
    begin
      next_s.ext_cnt = 12'h001;
      if (s.ext_cnt >= BCS_PER_MIN && s.ext_cnt < BCS_SYNC_MAX)
      begin
        next_s.ext_per = s.ext_cnt;
        next_s.ext_ok = 1'b1;
      end
    end
    else if (s.ext_cnt < BCS_SYNC_MAX)
      next_s.ext_cnt = s.ext_cnt + 12'h001;
    else
      next_s.ext_ok = 1'b0;

    // mode sequencing; shutdown and thermal take precedence
    if (!por)
    begin
      next_s.st = BCS_OFF;
      next_s.ss = '0;
      next_s.oc = 1'b0;
    end
    else if (hot)
    begin
      next_s.st = BCS_HOT;
      next_s.ss = '0;
      next_s.oc = 1'b0;
    end
    else
    begin
      unique case (s.st)
        BCS_OFF, BCS_HOT:
        begin
          next_s.st = BCS_SS;
          next_s.ss = '0;
          next_s.ss_div = '0;
        end
        BCS_SS, BCS_RUN:
        begin
          if (samp_hit && over)
          begin
            next_s.st = BCS_HIC;
            next_s.oc = 1'b1;
            next_s.hic = '0;
            next_s.ss = '0;
          end
          else if (s.st == BCS_SS)
          begin
            if (s.ss >= BCS_SS_TOP_MV)
              next_s.st = BCS_RUN;
            else if (s.ss_div == 8'(BCS_SS_STEP_CYC - 1))
            begin
              next_s.ss_div = '0;
              next_s.ss = s.ss + 11'h001;
            end
            else
              next_s.ss_div = s.ss_div + 8'h01;
          end
        end
        BCS_HIC:
        begin
          if (s.hic == BCS_HIC_W'(HICCUP_CYC - 1))
          begin
            next_s.st = BCS_SS;
            next_s.oc = 1'b0;
            next_s.ss_div = '0;
          end
          else
            next_s.hic = s.hic + 20'h00001;
        end
      endcase
    end

    // gate-bias level from consecutive zero crossings
    if (!s.s2.enable_ok)
    begin
      next_s.drv.ldo_high = 1'b0;
      next_s.zc_cnt = '0;
    end
    else if (s.st == BCS_OFF)
    begin
      next_s.drv.ldo_high = 1'b1;
      next_s.zc_cnt = '0;
    end
    else if (ls_fall)
    begin
      if (!s.s2.zero_cross)
      begin
        next_s.zc_cnt = '0;
        next_s.drv.ldo_high = 1'b1;
      end
      else if (s.zc_cnt < BCS_ZC_COUNT - 9'h001)
        next_s.zc_cnt = s.zc_cnt + 9'h001;
      else
      begin
        next_s.zc_cnt = BCS_ZC_COUNT;
        next_s.drv.ldo_high = 1'b0;
      end
    end

    next_s.drv.high_side_drive = hs_on;
    next_s.drv.low_side_drive = ls_on;
    next_s.drv.feed_forward_on = s.s2.power_input_high;
    next_s.drv.overcurrent_flag = next_s.oc;

    // ahb-lite: zero wait states, read data is registered at address phase
    stat = '0;
    stat.ext_sync = s.ext_ok;
    stat.feed_fwd = s.drv.feed_forward_on;
    stat.ldo_high = s.drv.ldo_high;
    stat.thermal = hot;
    stat.oc = s.oc;
    stat.mode = s.st;
    ap = hsel && htrans[1] && hready;
    next_s.a_wr = ap && hwrite;
    if (ap)
      next_s.a_addr = haddr;
    if (ap && !hwrite)
    begin
      unique case (haddr)
        BCS_REG_PERIOD: next_s.rdata = {20'h00000, s.per_fr};
        BCS_REG_DUTY:   next_s.rdata = {20'h00000, s.duty};
        BCS_REG_STATUS: next_s.rdata = stat;
        BCS_REG_LEVEL:  next_s.rdata = {4'h0, s.per, 5'h00, s.ss};
        default:        next_s.rdata = '0;
      endcase
    end
    if (s.a_wr)
    begin
      if (s.a_addr == BCS_REG_PERIOD)
        next_s.per_fr = (hwdata[11:0] < BCS_PER_MIN) ? BCS_PER_MIN
                                                      : hwdata[11:0];
      else if (s.a_addr == BCS_REG_DUTY)
        next_s.duty = hwdata[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.st <= BCS_OFF;
      s.per <= BCS_PER_RESET;
      s.per_fr <= BCS_PER_RESET;
      s.duty <= BCS_DUTY_RESET;
    end
    else
      s <= next_s;
  end

  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign drive = s.drv;
  assign ss_level = s.ss;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  en_off_a: assert property (!s.s2.enable_ok |=>
    !drive.high_side_drive && !drive.low_side_drive)
    else $error("drive on while enable low");
  hot_off_a: assert property (s.st == BCS_HOT |=>
    !drive.high_side_drive && !drive.low_side_drive && s.ss == 0)
    else $error("drive on in thermal shutdown");
  oc_trip_a: assert property (active && samp_hit && over && por
    && !hot |=> s.st == BCS_HIC && drive.overcurrent_flag)
    else $error("overcurrent sample missed");
  hic_hold_a: assert property (s.st == BCS_HIC |->
    s.ss == 0 && s.oc)
    else $error("soft-start not held during hiccup");
  hic_end_a: assert property (s.st == BCS_HIC
    && s.hic == BCS_HIC_W'(HICCUP_CYC - 1) && por && !hot
    |=> s.st == BCS_SS && !s.oc)
    else $error("hiccup did not end into soft-start");
  ss_rate_a: assert property (s.st == BCS_SS && $changed(s.ss)
    && s.ss != 0 |-> $past(s.ss_div) == 8'(BCS_SS_STEP_CYC - 1))
    else $error("soft-start step too early");
  per_slew_a: assert property ($changed(s.per) |->
    (s.per == $past(s.per) + 12'h001) || (s.per + 12'h001 == $past(s.per)))
    else $error("switching period jumped");
  ldo_start_a: assert property (s.st == BCS_OFF && s.s2.enable_ok
    ##1 s.st == BCS_SS |-> drive.ldo_high)
    else $error("turn-on without high bias level");
  ldo_off_a: assert property (!s.s2.enable_ok |=> !drive.ldo_high)
    else $error("bias level high while enable low");
  zc_clr_a: assert property (ls_fall && !s.s2.zero_cross
    && s.s2.enable_ok && s.st != BCS_OFF |=> drive.ldo_high && s.zc_cnt == 0)
    else $error("zero-crossing counter not cleared");
  ff_follow_a: assert property (s.s2.power_input_high |=>
    drive.feed_forward_on)
    else $error("feed-forward select not applied");
  oc_sense_a: assert property (s.st != BCS_HIC ##1 s.st == BCS_HIC
    |-> $past(drive.low_side_drive, 3))
    else $error("overcurrent taken with low side off");

endmodule

/* bcs_power_stage.sv */
/*
  Far-side model of the buck supervisor: switch current comparator,
  temperature, enable, strap and sync sources, all shaped by the bench.
  Assumes the bench sets the wanted sense levels right after a rising edge.
*/
`timescale 1ns/100ps
module bcs_power_stage
  import bcs_pkg::*;
(
  input  wire logic       hclk,
  input  wire bcs_sense_t want,
  input  wire logic       sync_on,
  input  wire bcs_drive_t drive,
  output bcs_sense_t      sense
);
  localparam int unsigned SYNC_HALF = 20;
  logic        sync_clk = 1'b0;
  int unsigned cnt      = 0;

  // the sync line stands low while no external clock is applied
  always @(posedge hclk)
  begin
    cnt      <= (cnt + 1) % (2 * SYNC_HALF);
    sync_clk <= sync_on && (cnt < SYNC_HALF);
  end

  // the current code means nothing unless the low side conducts, so a
  // sample taken at the wrong moment sees the inverse and may trip
  always_comb
  begin
    sense                     = want;
    sense.freq_set_sync_input = sync_clk;
    if (drive.low_side_drive !== 1'b1)
      sense.ls_current = ~want.ls_current;
  end
endmodule

/* bcs_fault_bias_tb.sv */
/*
  Self-checking bench of the buck fault and bias supervisor.
  Assumes a 40 MHz hclk, a zero-wait AHB-Lite slave and a short hiccup.
*/
`timescale 1ns/100ps
module bcs_fault_bias_tb import bcs_pkg::*;;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  bcs_sense_t  want    = '0;
  logic        sync_on = 1'b0;
  bcs_sense_t  sense;
  bcs_drive_t  drive;
  logic [10:0] ss_level;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          n;
  logic [31:0] rd;
  logic [31:0] wd;

  always #12.5 hclk = ~hclk;

  bcs_fault_bias #(.HICCUP_CYC(64)) dut_u (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .sense     (sense),
    .drive     (drive),
    .ss_level  (ss_level)
  );

  bcs_power_stage stage_u (
    .hclk    (hclk),
    .want    (want),
    .sync_on (sync_on),
    .drive   (drive),
    .sense   (sense)
  );

  function automatic logic [7:0] lim_of(input int s);
    return (s == 1) ? BCS_LIM_HIGH : (s == 2) ? BCS_LIM_LOW : BCS_LIM_FLOAT;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_rdy;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0, "bus response");
  endtask

  task automatic wait_flag(input logic v);
    n = 0;
    while (drive.overcurrent_flag !== v && n < 1000)
    begin
      @(negedge hclk);
      n++;
    end
  endtask

  // counts cycles in which either gate drive is seen on
  task automatic off_for(input int k);
    n = 0;
    repeat (k)
    begin
      @(negedge hclk);
      if (drive.high_side_drive !== 1'b0 || drive.low_side_drive !== 1'b0)
        n++;
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(negedge hclk);
  endtask

  initial
  begin
    #2000000;
    n_errors++;
    conclude();
  end

  initial
  begin
    want.bias_ok = 1'b1;
    void'($urandom(32'h64d898aa));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, BCS_REG_PERIOD, 32'h0);
    chk(rd, 32'h42, "period reset");
    bus(1'b0, BCS_REG_DUTY, 32'h0);
    chk(rd, 32'h8, "duty reset");
    bus(1'b0, BCS_REG_STATUS, 32'h0);
    chk(rd, 32'h0, "status reset");
    bus(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    off_for(70);
    chk(n, 0, "drive while disabled");
    @(posedge hclk);
    want.enable_ok <= 1'b1;
    settle(8);
    chk(drive.ldo_high, 1'b1, "bias level at turn-on");
    bus(1'b0, BCS_REG_STATUS, 32'h0);
    chk(rd[2:0], 3'h1, "soft-start entered");
    settle(1000);
    chk(ss_level >= 11'h009 && ss_level <= 11'h00B, 1'b1, "ramp");
    for (int s = 0; s < 3; s++)
    begin
      @(posedge hclk);
      want.strap_high <= (s == 1);
      want.strap_low  <= (s == 2);
      want.ls_current <= lim_of(s);
      settle(300);
      chk(drive.overcurrent_flag, 1'b0, "trip at limit");
      @(posedge hclk);
      want.ls_current <= lim_of(s) + 8'h01;
      wait_flag(1'b1);
      chk(n < 150, 1'b1, "no trip above limit");
      settle(2);
      chk(ss_level, 11'h000, "ramp held in hiccup");
      wait_flag(1'b0);
      chk(n >= 56 && n <= 68, 1'b1, "hiccup length");
      wait_flag(1'b1);
      chk(n < 150, 1'b1, "no repeat hiccup");
      @(posedge hclk);
      want.ls_current <= 8'($urandom_range(lim_of(s) - 1, 0));
      wait_flag(1'b0);
      settle(300);
      chk(drive.overcurrent_flag, 1'b0, "flag after recovery");
      chk(ss_level > 11'h000, 1'b1, "no restart ramp");
    end
    @(posedge hclk);
    want.thermal_trip <= 1'b1;
    settle(5);
    off_for(140);
    chk(n, 0, "drive while hot");
    chk(ss_level, 11'h000, "ramp while hot");
    bus(1'b0, BCS_REG_STATUS, 32'h0);
    chk(rd[2:0], 3'h4, "hot mode");
    @(posedge hclk);
    want.thermal_trip <= 1'b0;
    settle(5);
    bus(1'b0, BCS_REG_STATUS, 32'h0);
    chk(rd[2:0], 3'h1, "restart after cooling");
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge hclk);
      want.power_input_high <= v[0];
      settle(5);
      chk(drive.feed_forward_on, v[0], "feed-forward select");
    end
    @(posedge hclk);
    sync_on <= 1'b1;
    settle(400);
    bus(1'b0, BCS_REG_LEVEL, 32'h0);
    chk(rd[27:16] > 12'h028 && rd[27:16] < 12'h042, 1'b1, "sync step");
    settle(3000);
    bus(1'b0, BCS_REG_LEVEL, 32'h0);
    chk(rd[27:16], 12'h028, "locked period");
    @(posedge hclk);
    sync_on <= 1'b0;
    settle(4400);
    bus(1'b0, BCS_REG_LEVEL, 32'h0);
    chk(rd[27:16] > 12'h028 && rd[27:16] < 12'h042, 1'b1, "free step");
    settle(3000);
    bus(1'b0, BCS_REG_LEVEL, 32'h0);
    chk(rd[27:16], 12'h042, "free period");
    @(posedge hclk);
    want.zero_cross <= 1'b1;
    settle(250 * 66);
    chk(drive.ldo_high, 1'b1, "bias lowered early");
    settle(12 * 66);
    chk(drive.ldo_high, 1'b0, "bias not lowered");
    @(posedge hclk);
    want.zero_cross <= 1'b0;
    settle(140);
    chk(drive.ldo_high, 1'b1, "bias not restored");
    @(posedge hclk);
    want.enable_ok <= 1'b0;
    settle(5);
    off_for(140);
    chk(n, 0, "drive in shutdown");
    chk(drive.ldo_high, 1'b0, "bias in shutdown");
    @(posedge hclk);
    want.enable_ok <= 1'b1;
    settle(6);
    chk(drive.ldo_high, 1'b1, "bias at restart");
    off_for(140);
    chk(n, 140, "drive idle while running");
    for (int i = 0; i < 4; i++)
    begin
      wd = $urandom | 32'h8;
      bus(1'b1, BCS_REG_PERIOD, wd);
      bus(1'b0, BCS_REG_PERIOD, 32'h0);
      chk(rd, {20'h0, wd[11:0]}, "period readback");
    end
    conclude();
  end
endmodule
